//--- vsh_core.sv
// velocity status flags, homing sequence flags and their object entries
`timescale 1ns/1ns
`default_nettype none
`include "vsh_defs.svh"
module vsh_core #(
    parameter int CYCLES_PER_MS = `VSH_CYCLES_PER_MS,
    parameter int RATED_RPM = 3000,
    parameter logic [31:0] SWITCH_SEARCH_SPEED_DEFAULT = 32'h0000_0064,
    parameter logic [31:0] INDEX_SEARCH_SPEED_DEFAULT = 32'h0000_000A,
    parameter int SPEED_NUM = 1,
    parameter int SPEED_SHIFT = 0
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire vsh_pkg::vsh_od_req_t od_req_i,
    output vsh_pkg::vsh_od_rsp_t od_rsp_o,
    input wire logic [7:0] operating_mode_i,
    input wire logic [15:0] control_word_i,
    input wire logic signed [31:0] actual_speed_i,
    input wire logic speed_unit_select_i,
    input wire logic homing_finished_i,
    input wire logic index_phase_i,
    output logic status_target_reached_o,
    output logic status_bit12_o,
    output logic homing_start_o,
    output logic homing_active_o,
    output logic [31:0] homed_position_o,
    output logic [7:0] homing_method_o,
    output logic [31:0] homing_speed_ref_o
);
    logic [15:0] speed_tolerance_band;
    logic [15:0] speed_tolerance_dwell;
    logic [15:0] standstill_limit;
    logic [31:0] homing_offset;
    logic [7:0] homing_method_select;
    logic [31:0] switch_search_speed;
    logic [31:0] index_search_speed;
    logic [31:0] homing_ramp_time;
    logic signed [31:0] commanded_speed;
    logic [16:0] ms_div;
    logic ms_tick;
    logic [15:0] dwell_cnt;
    logic cw_start_prev;
    logic trigger;
    logic in_win;
    logic zero_cond;
    logic mode_vel;
    logic mode_home;
    logic halt;
    logic home_done;
    logic next_bit10;
    logic next_bit12;
    logic [32:0] cmd_motor;
    logic [32:0] speed_err;
    logic [31:0] ramp_target;
    vsh_pkg::vsh_home_state_t home_state;
    vsh_pkg::vsh_home_state_t next_home_state;
    logic wr_ok;
    logic [31:0] rd_data;
    logic rd_hit;

    // magnitude of a signed 33-bit value
    function automatic logic [32:0] abs33(input logic signed [32:0] v);
        abs33 = v[32] ? 33'(-v) : 33'(v);
    endfunction

    // user units/s to 0.1 rpm; the scale is a plain ratio set by parameter
    function automatic logic signed [32:0] to_motor(input logic signed [31:0] v, input logic user);
        logic signed [63:0] p;
        p = 64'(v) * 64'(signed'(SPEED_NUM));
        to_motor = user ? 33'(p >>> SPEED_SHIFT) : 33'(v);
    endfunction

    assign mode_vel = (operating_mode_i == `VSH_MODE_VELOCITY);
    assign mode_home = (operating_mode_i == `VSH_MODE_HOMING); // [R7]
    assign halt = control_word_i[`VSH_CW_HALT_BIT];
    assign home_done = (home_state == vsh_pkg::VSH_HOME_DONE);
    assign cmd_motor = to_motor(commanded_speed, !speed_unit_select_i); // [R3]
    assign speed_err = abs33(33'(signed'(cmd_motor) - 33'(actual_speed_i)));
    assign in_win = speed_err < 33'(speed_tolerance_band); // [R1]
    assign zero_cond = abs33(33'(actual_speed_i)) < 33'(standstill_limit); // [R2]
    // start only when the start bit rises with the low nibble at 15, so a stale start bit cannot retrigger
    assign trigger = mode_home && (control_word_i[3:0] == `VSH_CW_ENABLED)
        && control_word_i[`VSH_CW_START_BIT] && !cw_start_prev; // [R12]

    // millisecond tick for the dwell timer
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ms_div <= 17'h0_0000;
            ms_tick <= 1'b0;
        end else if (ce_i) begin
            ms_tick <= (ms_div == 17'(CYCLES_PER_MS - 1));
            ms_div <= (ms_div == 17'(CYCLES_PER_MS - 1)) ? 17'h0_0000 : ms_div + 17'h0_0001;
        end
    end

    // dwell counter saturates at the dwell value
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dwell_cnt <= 16'h0000;
        end else if (ce_i) begin
            if (!in_win || !mode_vel) begin
                dwell_cnt <= 16'h0000; // [R18]
            end else if (ms_tick && dwell_cnt < speed_tolerance_dwell) begin
                dwell_cnt <= dwell_cnt + 16'h0001; // [R5]
            end
        end
    end

    always_comb begin
        next_home_state = home_state;
        case (home_state)
            vsh_pkg::VSH_HOME_IDLE: begin
                if (trigger) begin
                    next_home_state = vsh_pkg::VSH_HOME_RUN;
                end
            end
            vsh_pkg::VSH_HOME_RUN: begin
                if (!mode_home) begin
                    next_home_state = vsh_pkg::VSH_HOME_IDLE;
                end else if (homing_finished_i) begin
                    next_home_state = vsh_pkg::VSH_HOME_DONE; // [R13]
                end
            end
            vsh_pkg::VSH_HOME_DONE: begin
                if (trigger) begin
                    next_home_state = vsh_pkg::VSH_HOME_RUN; // [R13]
                end
            end
            default: begin
                next_home_state = vsh_pkg::VSH_HOME_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            home_state <= vsh_pkg::VSH_HOME_IDLE;
            cw_start_prev <= 1'b0;
            homing_start_o <= 1'b0;
            homing_active_o <= 1'b0;
        end else if (ce_i) begin
            home_state <= next_home_state;
            cw_start_prev <= control_word_i[`VSH_CW_START_BIT];
            homing_start_o <= trigger;
            homing_active_o <= (next_home_state == vsh_pkg::VSH_HOME_RUN);
        end
    end

    // offset is the position the drive reports once homing completes
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            homed_position_o <= 32'h0000_0000;
        end else if (ce_i && home_state == vsh_pkg::VSH_HOME_RUN && homing_finished_i && mode_home) begin
            homed_position_o <= homing_offset; // [R8]
        end
    end

    always_comb begin
        next_bit10 = 1'b0;
        next_bit12 = 1'b0;
        if (mode_vel) begin
            next_bit10 = in_win && (dwell_cnt >= speed_tolerance_dwell); // [R1]
            next_bit12 = zero_cond; // [R2]
        end else if (mode_home) begin
            next_bit12 = home_done; // [R13]
            if (halt) begin
                next_bit10 = (actual_speed_i == 32'sh0000_0000); // [R14]
            end else begin
                next_bit10 = home_done; // [R15]
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_target_reached_o <= 1'b0;
            status_bit12_o <= 1'b0;
        end else if (ce_i) begin
            status_target_reached_o <= next_bit10;
            status_bit12_o <= next_bit12;
        end
    end

    // write acceptance with range checks; out-of-range writes abort
    always_comb begin
        wr_ok = 1'b0;
        case (od_req_i.index)
            `VSH_IDX_BAND: wr_ok = (od_req_i.sub == 8'h00) && (od_req_i.data <= `VSH_MAX_BAND); // [R4]
            `VSH_IDX_DWELL: wr_ok = (od_req_i.sub == 8'h00) && (od_req_i.data <= `VSH_MAX_U16); // [R5]
            `VSH_IDX_STILL: wr_ok = (od_req_i.sub == 8'h00) && (od_req_i.data <= `VSH_MAX_U16); // [R6]
            `VSH_IDX_OFFSET: wr_ok = (od_req_i.sub == 8'h00);
            `VSH_IDX_METHOD: wr_ok = (od_req_i.sub == 8'h00) && (od_req_i.data <= `VSH_MAX_METHOD); // [R9]
            `VSH_IDX_SPEEDS: wr_ok = (od_req_i.sub == `VSH_SUB_SWITCH) || (od_req_i.sub == `VSH_SUB_INDEX); // [R10]
            `VSH_IDX_RAMP: wr_ok = (od_req_i.sub == 8'h00);
            `VSH_IDX_CMD: wr_ok = (od_req_i.sub == 8'h00); // [R3]
            default: wr_ok = 1'b0;
        endcase
    end

    always_comb begin
        rd_hit = (od_req_i.sub == 8'h00);
        rd_data = 32'h0000_0000;
        case (od_req_i.index)
            `VSH_IDX_BAND: rd_data = {16'h0000, speed_tolerance_band};
            `VSH_IDX_DWELL: rd_data = {16'h0000, speed_tolerance_dwell};
            `VSH_IDX_STILL: rd_data = {16'h0000, standstill_limit};
            `VSH_IDX_OFFSET: rd_data = homing_offset;
            `VSH_IDX_METHOD: rd_data = {24'h00_0000, homing_method_select};
            `VSH_IDX_SPEEDS: begin
                rd_hit = (od_req_i.sub <= `VSH_SUB_INDEX);
                case (od_req_i.sub)
                    `VSH_SUB_COUNT: rd_data = `VSH_SPEEDS_COUNT; // [R10]
                    `VSH_SUB_SWITCH: rd_data = switch_search_speed;
                    `VSH_SUB_INDEX: rd_data = index_search_speed;
                    default: rd_data = 32'h0000_0000;
                endcase
            end
            `VSH_IDX_RAMP: rd_data = homing_ramp_time;
            `VSH_IDX_CMD: rd_data = commanded_speed;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            speed_tolerance_band <= `VSH_RST_BAND; // [R4]
            speed_tolerance_dwell <= `VSH_RST_DWELL; // [R5]
            standstill_limit <= `VSH_RST_STILL; // [R6]
            homing_offset <= 32'h0000_0000;
            homing_method_select <= 8'h00; // [R9]
            switch_search_speed <= SWITCH_SEARCH_SPEED_DEFAULT;
            index_search_speed <= INDEX_SEARCH_SPEED_DEFAULT;
            homing_ramp_time <= `VSH_RST_RAMP; // [R11]
            commanded_speed <= 32'sh0000_0000; // [R3]
        end else if (ce_i && od_req_i.wr && wr_ok) begin
            case (od_req_i.index)
                `VSH_IDX_BAND: speed_tolerance_band <= od_req_i.data[15:0];
                `VSH_IDX_DWELL: speed_tolerance_dwell <= od_req_i.data[15:0];
                `VSH_IDX_STILL: standstill_limit <= od_req_i.data[15:0];
                `VSH_IDX_OFFSET: homing_offset <= od_req_i.data;
                `VSH_IDX_METHOD: homing_method_select <= od_req_i.data[7:0];
                `VSH_IDX_SPEEDS: begin
                    if (od_req_i.sub == `VSH_SUB_SWITCH) begin
                        switch_search_speed <= od_req_i.data;
                    end else begin
                        index_search_speed <= od_req_i.data;
                    end
                end
                `VSH_IDX_RAMP: homing_ramp_time <= od_req_i.data;
                `VSH_IDX_CMD: commanded_speed <= od_req_i.data;
                default: begin
                end
            endcase
        end
    end

    // answer one cycle after the request; write wins if both strobes are high
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            od_rsp_o <= '0;
        end else if (ce_i) begin
            od_rsp_o.ack <= od_req_i.wr || od_req_i.rd;
            od_rsp_o.err <= od_req_i.wr ? !wr_ok : (od_req_i.rd && !rd_hit);
            od_rsp_o.data <= (od_req_i.rd && !od_req_i.wr && rd_hit) ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            homing_method_o <= 8'h00;
        end else if (ce_i) begin
            homing_method_o <= homing_method_select;
        end
    end

    // ramp heads for the phase speed while running with halt clear and back to zero otherwise
    assign ramp_target = (home_state != vsh_pkg::VSH_HOME_RUN || halt) ? 32'h0000_0000
        : (index_phase_i ? index_search_speed : switch_search_speed);

    vsh_ramp #(
        .RATED_RPM(RATED_RPM)
    ) u_ramp (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .target_i(ramp_target),
        .ramp_ms_i(homing_ramp_time),
        .cycles_per_ms_i(32'(CYCLES_PER_MS)),
        .ref_o(homing_speed_ref_o)
    );

    property p_vel_out_of_band;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && mode_vel && !in_win) |=> !status_target_reached_o;
    endproperty
    a_vel_out_of_band: assert property (p_vel_out_of_band) else $error("bit 10 set outside band"); // [R1]

    property p_dwell_restart;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && mode_vel && !in_win) |=> (dwell_cnt == 16'h0000);
    endproperty
    a_dwell_restart: assert property (p_dwell_restart) else $error("dwell timer not restarted"); // [R18]

    property p_vel_zero_speed;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && mode_vel) |=> (status_bit12_o == $past(zero_cond));
    endproperty
    a_vel_zero_speed: assert property (p_vel_zero_speed) else $error("zero speed flag wrong"); // [R2]

    property p_home_trigger_clears;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && trigger) ##1 (ce_i && mode_home) |-> (home_state == vsh_pkg::VSH_HOME_RUN) ##1 !status_bit12_o;
    endproperty
    a_home_trigger_clears: assert property (p_home_trigger_clears) else $error("trigger did not clear bit 12"); // [R13]

    property p_home_done_sets;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && mode_home && home_state == vsh_pkg::VSH_HOME_RUN && homing_finished_i) ##1 (ce_i && mode_home)
        |=> status_bit12_o;
    endproperty
    a_home_done_sets: assert property (p_home_done_sets) else $error("bit 12 not set after homing"); // [R13]

    property p_halt_zero;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && mode_home && halt) |=> (status_target_reached_o == ($past(actual_speed_i) == 32'sh0000_0000));
    endproperty
    a_halt_zero: assert property (p_halt_zero) else $error("halted bit 10 not tied to zero speed"); // [R14]

    property p_nohalt_done;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && mode_home && !halt) |=> (status_target_reached_o == $past(home_done));
    endproperty
    a_nohalt_done: assert property (p_nohalt_done) else $error("bit 10 differs from homing done"); // [R15]

    property p_method_range;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && od_req_i.wr && od_req_i.index == `VSH_IDX_METHOD && od_req_i.data > `VSH_MAX_METHOD)
        |=> (od_rsp_o.err && homing_method_select == $past(homing_method_select));
    endproperty
    a_method_range: assert property (p_method_range) else $error("out of range method accepted"); // [R9]

    property p_count_sub;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && od_req_i.rd && !od_req_i.wr && od_req_i.index == `VSH_IDX_SPEEDS && od_req_i.sub == `VSH_SUB_COUNT)
        |=> (od_rsp_o.ack && od_rsp_o.data == `VSH_SPEEDS_COUNT);
    endproperty
    a_count_sub: assert property (p_count_sub) else $error("sub-index count not two"); // [R10]

    property p_band_range;
        @(posedge clock_i) disable iff (!rst_n_i)
        (ce_i && od_req_i.wr && od_req_i.index == `VSH_IDX_BAND && od_req_i.data > `VSH_MAX_BAND)
        |=> (od_rsp_o.err && speed_tolerance_band == $past(speed_tolerance_band));
    endproperty
    a_band_range: assert property (p_band_range) else $error("out of range band accepted"); // [R4]
endmodule // vsh_core
`default_nettype wire

//--- vsh_defs.svh
// constants for the velocity status and homing block
// Summary of operation
// (R1) velocity mode: status bit 10 set while speed error stays inside band for dwell time
// (R2) velocity mode: status bit 12 set while absolute actual speed is below standstill limit
// (R3) commanded speed is signed 32-bit, default zero, user units/s when unit select is zero
// (R4) speed tolerance band object, 0.1 rpm units, accepts 0 to 32767, default 100
// (R5) speed tolerance dwell object, 16-bit milliseconds, default 10
// (R6) standstill limit object, 16-bit, 0.1 rpm units, default 10
// (R7) controller writes operating mode 6 before using homing
// (R8) homing offset object in user position units becomes the homed position
// (R9) homing method select is signed 8-bit, accepts 0 to 35, default 0
// (R10) search speed array reports two sub-indexes; sub 1 switch speed, sub 2 index speed
// (R11) homing ramp time spans standstill to rated speed, scaled by the speed change
// (R12) controller steps control word 6, 7, 15, 31 then reads status word
// (R13) homing mode: bit 12 clears on homing trigger and sets when homing finishes
// (R14) homing mode with halt set: bit 10 set when speed is zero
// (R15) homing mode with halt clear: bit 10 equals the homing-complete flag
// (R16) configuring party presets absolute encoder pulses per revolution before homing
// (R17) velocity mode: controller writes mode 3, target, ramps, then control word 6, 7, 15
// (R18) dwell timer restarts whenever the speed error leaves the band
`ifndef VSH_DEFS_SVH
`define VSH_DEFS_SVH
`define VSH_IDX_BAND 16'h606D
`define VSH_IDX_DWELL 16'h606E
`define VSH_IDX_STILL 16'h606F
`define VSH_IDX_OFFSET 16'h607C
`define VSH_IDX_METHOD 16'h6098
`define VSH_IDX_SPEEDS 16'h6099
`define VSH_IDX_RAMP 16'h609A
`define VSH_IDX_CMD 16'h60FF
`define VSH_RST_BAND 16'h0064
`define VSH_RST_DWELL 16'h000A
`define VSH_RST_STILL 16'h000A
`define VSH_RST_RAMP 32'h0000_01F4
`define VSH_MAX_BAND 32'h0000_7FFF
`define VSH_MAX_METHOD 32'h0000_0023
`define VSH_MAX_U16 32'h0000_FFFF
`define VSH_SPEEDS_COUNT 32'h0000_0002
`define VSH_SUB_COUNT 8'h00
`define VSH_SUB_SWITCH 8'h01
`define VSH_SUB_INDEX 8'h02
`define VSH_MODE_VELOCITY 8'h03
`define VSH_MODE_HOMING 8'h06
`define VSH_CW_ENABLED 4'hF
`define VSH_CW_START_BIT 4
`define VSH_CW_HALT_BIT 8
`define VSH_MS_NS 1000000
`define VSH_CLK_NS 8
`define VSH_CYCLES_PER_MS (`VSH_MS_NS / `VSH_CLK_NS)
`endif

//--- vsh_pkg.sv
// types shared by the velocity status and homing block
`default_nettype none
package vsh_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] data;
    } vsh_od_req_t;
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] data;
    } vsh_od_rsp_t;
    typedef enum logic [1:0] {
        VSH_HOME_IDLE = 2'b00,
        VSH_HOME_RUN = 2'b01,
        VSH_HOME_DONE = 2'b11
    } vsh_home_state_t;
endpackage
`default_nettype wire

//--- vsh_ramp.sv
// homing speed ramp generator
`timescale 1ns/1ns
`default_nettype none
module vsh_ramp #(
    parameter int RATED_RPM = 3000
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [31:0] target_i,
    input wire logic [31:0] ramp_ms_i,
    input wire logic [31:0] cycles_per_ms_i,
    output logic [31:0] ref_o
);
    logic [63:0] acc;
    logic [63:0] den;
    logic [63:0] acc_sum;

    // one unit per den/rated cycles: a full-scale change takes ramp_ms
    assign den = 64'(ramp_ms_i) * 64'(cycles_per_ms_i);
    assign acc_sum = acc + 64'(unsigned'(RATED_RPM));

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_o <= 32'h0000_0000;
            acc <= 64'h0000_0000_0000_0000;
        end else if (ce_i) begin
            if (ref_o == target_i) begin
                acc <= 64'h0000_0000_0000_0000;
            end else if (den == 64'h0000_0000_0000_0000) begin
                ref_o <= target_i; // [R11]
            end else if (acc_sum >= den) begin
                acc <= acc_sum - den;
                ref_o <= (ref_o < target_i) ? ref_o + 32'h0000_0001 : ref_o - 32'h0000_0001; // [R11]
            end else begin
                acc <= acc_sum;
            end
        end
    end
endmodule // vsh_ramp
`default_nettype wire

//--- vsh_ctrl_model.sv
// fieldbus controller model: object accesses and control word steps
`timescale 1ns/1ns
`default_nettype none
module vsh_ctrl_model (
    input wire logic clock_i,
    output var vsh_pkg::vsh_od_req_t od_req_o,
    output logic [7:0] mode_o,
    output logic [15:0] cw_o
);
    logic [15:0] steps [4] = '{16'h0006, 16'h0007, 16'h000F, 16'h001F};
    // encoder pulses per rev is not held by this block, nothing to preset
    initial begin
        od_req_o = '0;
        mode_o = 8'h00;
        cw_o = 16'h0000;
    end
    // one access, held across exactly one taking edge
    task automatic obj(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
        @(negedge clock_i);
        od_req_o = '{wr: w, rd: !w, index: idx, sub: sub, data: d};
        @(negedge clock_i);
        // released bus shows inverted leftovers so stale values cannot pass
        od_req_o = '{wr: 1'b0, rd: 1'b0, index: ~idx, sub: ~sub, data: ~d};
    endtask
    task automatic set_mode(input logic [7:0] m);
        @(negedge clock_i);
        mode_o = m;
    endtask
    task automatic set_cw(input logic [15:0] v);
        @(negedge clock_i);
        cw_o = v;
    endtask
    // 6, 7, 15 and for homing 31; returns one cycle after the last step
    task automatic seq(input bit home);
        for (int i = 0; i < (home ? 4 : 3); i++) begin
            @(negedge clock_i);
            cw_o = steps[i];
            @(negedge clock_i);
        end
    endtask
endmodule // vsh_ctrl_model
`default_nettype wire

//--- testbench.sv
// self-checking bench for the velocity status and homing core
`timescale 1ns/1ns
`default_nettype none
`include "vsh_defs.svh"
module testbench;
    typedef struct {logic err; logic [31:0] data; bit use_data;} vsh_exp_t;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i;
    logic unit_sel;
    logic finished;
    logic phase;
    logic signed [31:0] actual = 32'sh0000_0000;
    vsh_pkg::vsh_od_req_t od_req;
    vsh_pkg::vsh_od_rsp_t od_rsp;
    logic [7:0] mode;
    logic [15:0] cw;
    logic reached, bit12, start, active;
    logic [31:0] homed, sref, offs;
    logic [7:0] method;
    vsh_exp_t exp_q[$];
    vsh_exp_t e;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    vsh_ctrl_model ctrl_u (.clock_i(clock_i), .od_req_o(od_req), .mode_o(mode), .cw_o(cw));
    vsh_core #(.CYCLES_PER_MS(10)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .od_req_i(od_req),
        .od_rsp_o(od_rsp), .operating_mode_i(mode), .control_word_i(cw), .actual_speed_i(actual),
        .speed_unit_select_i(unit_sel), .homing_finished_i(finished), .index_phase_i(phase),
        .status_target_reached_o(reached), .status_bit12_o(bit12), .homing_start_o(start),
        .homing_active_o(active), .homed_position_o(homed), .homing_method_o(method), .homing_speed_ref_o(sref));
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic flag(input logic got, input logic want);
        chk({31'h0, got}, {31'h0, want});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // reads pass the expected data in d; writes expect only the err bit
    task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                       input logic err);
        exp_q.push_back('{err, w ? 32'h0 : d, !w});
        ctrl_u.obj(w, idx, sub, w ? d : 32'h0);
    endtask
    task automatic end_of_test();
        $display("counts: %0d checks, %0d mismatches", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ack stands one cycle, so every answer is looked at exactly once
    always @(negedge clock_i) begin
        if (od_rsp.ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h0000_0001, 32'h0000_0000);
            end else begin
                e = exp_q.pop_front();
                flag(od_rsp.err, e.err);
                if (e.use_data) begin
                    chk(od_rsp.data, e.data);
                end
            end
        end
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        ce_i = 1'b1;
        unit_sel = 1'b0;
        finished = 1'b0;
        phase = 1'b0;
        void'($urandom(32'h690e_c67f));
        cyc(20);
        rst_n_i = 1'b1;
        acc(0, `VSH_IDX_BAND, 8'h00, 32'h0000_0064, 0);
        acc(0, `VSH_IDX_DWELL, 8'h00, 32'h0000_000A, 0);
        acc(0, `VSH_IDX_STILL, 8'h00, 32'h0000_000A, 0);
        acc(0, `VSH_IDX_METHOD, 8'h00, 32'h0000_0000, 0);
        acc(0, `VSH_IDX_RAMP, 8'h00, 32'h0000_01F4, 0);
        acc(0, `VSH_IDX_CMD, 8'h00, 32'h0000_0000, 0);
        acc(0, `VSH_IDX_OFFSET, 8'h00, 32'h0000_0000, 0);
        acc(0, `VSH_IDX_SPEEDS, 8'h00, 32'h0000_0002, 0);
        acc(0, `VSH_IDX_SPEEDS, 8'h01, 32'h0000_0064, 0);
        acc(0, `VSH_IDX_SPEEDS, 8'h02, 32'h0000_000A, 0);
        $display("test reset_values done");
        offs = {17'h0, 15'($urandom)};
        acc(1, `VSH_IDX_BAND, 8'h00, offs, 0);
        acc(0, `VSH_IDX_BAND, 8'h00, offs, 0);
        acc(1, `VSH_IDX_BAND, 8'h00, 32'h0000_8000, 1);
        acc(1, `VSH_IDX_METHOD, 8'h00, 32'h0000_0023, 0);
        acc(1, `VSH_IDX_METHOD, 8'h00, 32'h0000_0024, 1);
        acc(0, `VSH_IDX_METHOD, 8'h00, 32'h0000_0023, 0);
        acc(1, `VSH_IDX_SPEEDS, 8'h00, 32'h0000_0005, 1);
        acc(0, 16'h6000, 8'h00, 32'h0000_0000, 1);
        acc(1, `VSH_IDX_DWELL, 8'h00, 32'h0001_0000, 1);
        acc(1, `VSH_IDX_CMD, 8'h00, 32'hFFFF_FC18, 0);
        acc(0, `VSH_IDX_CMD, 8'h00, 32'hFFFF_FC18, 0);
        $display("test object_limits done");
        acc(1, `VSH_IDX_CMD, 8'h00, 32'h0000_03E8, 0);
        acc(1, `VSH_IDX_BAND, 8'h00, 32'h0000_0032, 0);
        acc(1, `VSH_IDX_DWELL, 8'h00, 32'h0000_0003, 0);
        // unit scale is one to one with the default ratio, so both selects must agree
        unit_sel = 1'($urandom);
        ctrl_u.set_mode(`VSH_MODE_VELOCITY);
        ctrl_u.seq(0);
        actual = 32'sh0000_0406;
        cyc(15);
        actual = 32'sh0000_0424;
        cyc(2);
        actual = 32'sh0000_03E8 + 32'($urandom_range(31));
        cyc(15);
        flag(reached, 1'b0);
        cyc(45);
        flag(reached, 1'b1);
        actual = 32'sh0000_041A;
        cyc(3);
        flag(reached, 1'b0);
        // limit 10: 5 and -9 are still, -10 and 10 are not
        for (int i = 0; i < 4; i++) begin
            actual = (i == 0) ? 32'sh5 : (i == 1) ? -32'sh0A : (i == 2) ? -32'sh09 : 32'sh0A;
            cyc(3);
            flag(bit12, i[0] == 1'b0);
        end
        $display("test velocity_flags done");
        offs = $urandom;
        phase = 1'($urandom);
        acc(1, `VSH_IDX_OFFSET, 8'h00, offs, 0);
        acc(1, `VSH_IDX_METHOD, 8'h00, 32'h0000_0011, 0);
        ctrl_u.set_mode(`VSH_MODE_HOMING);
        ctrl_u.seq(1);
        flag(start, 1'b1);
        flag(active, 1'b1);
        cyc(1);
        flag(start, 1'b0);
        flag(bit12, 1'b0);
        flag(reached, 1'b0);
        cyc(5);
        finished = 1'b1;
        cyc(1);
        finished = 1'b0;
        cyc(2);
        flag(bit12, 1'b1);
        flag(reached, 1'b1);
        flag(active, 1'b0);
        chk(homed, offs);
        chk({24'h0, method}, 32'h0000_0011);
        ctrl_u.set_cw(16'h011F);
        actual = 32'sh0000_0000;
        cyc(3);
        flag(reached, 1'b1);
        actual = 32'sh0000_0005;
        cyc(3);
        flag(reached, 1'b0);
        ctrl_u.set_cw(16'h000F);
        cyc(2);
        ctrl_u.set_cw(16'h001F);
        cyc(3);
        flag(bit12, 1'b0);
        flag(active, 1'b1);
        // freeze mid-ramp: the reference must not move while enable is low
        offs = sref;
        ce_i = 1'b0;
        cyc(5);
        chk(sref, offs);
        flag(active, 1'b1);
        ce_i = 1'b1;
        cyc(300);
        chk(sref, phase ? 32'h0000_000A : 32'h0000_0064);
        $display("test homing_sequence done");
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
